/* design/adcs_pkg.sv */
// Purpose: shared constants and types for the adc scan and reference control block
// Assumes: 8-bit register port, byte addresses 0x0..0x4
package adcs_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 4;
   // register byte addresses
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_SETUP = 4'h1;
   localparam logic [3:0] ADDR_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_RESULT = 4'h4;
   // field positions
   localparam int CTL_START_BIT = 0;
   localparam int CTL_FLUSH_BIT = 1;
   localparam int CTL_OVF_CLR_BIT = 2;
   localparam int STS_BUSY_BIT = 0;
   localparam int STS_REF_ON_BIT = 1;
   localparam int STS_OVF_BIT = 2;
   localparam int STS_COUNT_LSB = 3;
   // reset values
   localparam logic [6:0] CONFIG_RST = 7'h00;
   localparam logic [4:0] SETUP_RST = 5'h00;
   // scan constants
   localparam logic [2:0] REPEAT_LAST = 3'h7;
   localparam logic [3:0] UPPER_START_4 = 4'h2;
   localparam logic [3:0] UPPER_START_12 = 4'h6;
   localparam logic [7:0] BIPOLAR_FLIP = 8'h80;

   typedef enum logic [1:0] {
      SCAN_UP = 2'h0,
      SCAN_REPEAT = 2'h1,
      SCAN_UPPER = 2'h2,
      SCAN_SINGLE = 2'h3
   } adcs_scan_e;

   // config register layout, msb first
   typedef struct packed {
      logic single_ended_select;
      adcs_scan_e scan_mode;
      logic [3:0] channel_select;
   } adcs_cfg_s;

   // setup register layout, msb first
   typedef struct packed {
      logic ext_clock;
      logic bipolar;
      logic [2:0] reference_select;
   } adcs_setup_s;

   // one conversion request to the analog front end
   typedef struct packed {
      logic [3:0] pos;
      logic [3:0] neg;
      logic pos_gnd;
      logic neg_gnd;
   } adcs_conv_s;

   // internal reference held on permanently
   function automatic logic adcs_ref_always_on(input logic [2:0] sel);
      return sel[2] & (sel[1] | sel[0]);
   endfunction

   // internal reference powered only while converting
   function automatic logic adcs_ref_auto(input logic [2:0] sel);
      return sel == 3'h4;
   endfunction
endpackage

/* design/adcs_sync_edge.sv */
// Purpose: two-flop synchroniser with rising edge pulse
// Assumes: input asynchronous to core_clk_in
// Notes: first stage read only by the second
`timescale 1ns/1ns
`default_nettype none
module adcs_sync_edge
   import adcs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // async input
   input wire logic async_in,
   // synchronised outputs
   output logic level_out,
   output logic rise_out
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // synchroniser chain and history, reset to the pulled-up idle level
   // so that no false rising edge follows reset
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_out = sync_r;
   assign rise_out = sync_r & ~prev_r;
endmodule
`default_nettype wire

/* design/adcs_result_buf.sv */
// Purpose: in-order result store for scan conversions
// Assumes: push and pop from same clock
// Notes: push when full is dropped; pop when empty ignored
`timescale 1ns/1ns
`default_nettype none
module adcs_result_buf
   import adcs_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // control
   input wire logic flush_in,
   input wire logic push_in,
   input wire logic [WIDTH-1:0] push_data_in,
   input wire logic pop_in,
   // state
   output logic [WIDTH-1:0] head_out,
   output logic [$clog2(DEPTH):0] count_out,
   output logic full_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic do_push;
   logic do_pop;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("result buffer depth must be a power of two");
   end

   assign full_out = count_r == (AW + 1)'(DEPTH);
   assign do_push = push_in & ~full_out & ~flush_in;
   assign do_pop = pop_in & (count_r != '0) & ~flush_in;

   // storage
   always_ff @(posedge core_clk_in) begin
      if (do_push) begin
         mem_r[wr_ptr_r] <= push_data_in;
      end
   end

   // pointers and occupancy
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (flush_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
      end
   end

   assign head_out = (count_r == '0) ? '0 : mem_r[rd_ptr_r];
   assign count_out = count_r;
endmodule
`default_nettype wire

/* design/adcs_scan_ctrl.sv */
// Purpose: configuration decode, channel scan sequencing and result formatting
// Assumes: i2c engine supplies register access and not-acknowledge pulses on core clock
// Notes: front end returns offset binary codes; scl arrives asynchronously
`timescale 1ns/1ns
`default_nettype none
module adcs_scan_ctrl
   import adcs_pkg::*;
#(
   parameter int NUM_INPUTS = 12,
   parameter int BUF_DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // register port
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [DATA_W-1:0] rd_data_out,
   // serial bus side
   input wire logic scl_in,
   input wire logic master_nack_in,
   // analog front end
   output logic conv_start_out,
   output adcs_conv_s conv_req_out,
   input wire logic conv_done_in,
   input wire logic [DATA_W-1:0] conv_code_in,
   // reference control
   output logic int_ref_en_out,
   output logic ref_pin_drive_en_out,
   output logic ext_ref_sel_out,
   output logic vdd_ref_sel_out,
   output logic shared_pin_input_out,
   output logic busy_out
);
   localparam int CW = $clog2(BUF_DEPTH) + 1;
   localparam logic [3:0] LAST_CH = 4'(NUM_INPUTS - 1);
   localparam logic [3:0] UPPER_START = (NUM_INPUTS == 4) ? UPPER_START_4 : UPPER_START_12;

   if (NUM_INPUTS != 4 && NUM_INPUTS != 12) begin : g_bad_inputs
      $error("input count must be 4 or 12");
   end
   if (CW > 5) begin : g_bad_buf
      $error("buffer depth above 16 does not fit the status count");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ISSUE = 3'b010,
      ST_WAIT = 3'b100
   } adcs_state_e;

   adcs_state_e state_r;
   adcs_cfg_s cfg_r;
   adcs_setup_s setup_r;
   adcs_cfg_s wr_cfg;
   logic ref_hold_r;
   logic ovf_r;
   logic nack_r;
   logic [3:0] cur_r;
   logic [3:0] end_r;
   logic [2:0] rep_r;
   adcs_scan_e mode_r;
   logic step2_r;
   logic se_r;
   logic ext_r;
   logic [3:0] start_code;
   logic [3:0] end_code;
   logic [3:0] cs_lim;
   logic [4:0] next_code;
   logic scl_rise;
   logic wr_config;
   logic wr_setup;
   logic wr_control;
   logic start_req;
   logic flush;
   logic push;
   logic pop;
   logic full;
   logic [DATA_W-1:0] head;
   logic [CW-1:0] count;
   logic [DATA_W-1:0] result;
   logic continuous;
   logic done_last;
   logic refpin;
   adcs_conv_s req;

   // scl edges for external-clock conversions
   adcs_sync_edge u_scl_sync (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .async_in(scl_in),
      .level_out(),
      .rise_out(scl_rise)
   );

   // results kept in conversion order
   adcs_result_buf #(
      .WIDTH(DATA_W),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .flush_in(flush),
      .push_in(push),
      .push_data_in(result),
      .pop_in(pop),
      .head_out(head),
      .count_out(count),
      .full_out(full)
   );

   // register decode
   assign wr_config = wr_en_in && addr_in == ADDR_CONFIG;
   assign wr_setup = wr_en_in && addr_in == ADDR_SETUP;
   assign wr_control = wr_en_in && addr_in == ADDR_CONTROL;
   assign start_req = wr_control && wr_data_in[CTL_START_BIT] && state_r == ST_IDLE;
   assign flush = (wr_control && wr_data_in[CTL_FLUSH_BIT]) || start_req;
   assign pop = rd_en_in && addr_in == ADDR_RESULT;
   assign wr_cfg = adcs_cfg_s'(wr_data_in[6:0]);

   // configuration registers
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cfg_r <= adcs_cfg_s'(CONFIG_RST);
         setup_r <= adcs_setup_s'(SETUP_RST);
      end else begin
         if (wr_config) begin
            cfg_r <= wr_cfg;
            if (NUM_INPUTS == 4) begin
               cfg_r.channel_select <= {2'b00, wr_cfg.channel_select[1:0]};
            end
         end
         if (wr_setup) begin
            setup_r <= adcs_setup_s'(wr_data_in[4:0]);
         end
      end
   end

   // internal reference latch, changed only by a setup write
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ref_hold_r <= 1'b0;
      end else if (wr_setup) begin
         ref_hold_r <= adcs_ref_always_on(wr_data_in[2:0]);
      end
   end

   // reference and shared pin controls
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         int_ref_en_out <= 1'b0;
         ref_pin_drive_en_out <= 1'b0;
         ext_ref_sel_out <= 1'b0;
         vdd_ref_sel_out <= 1'b1;
         shared_pin_input_out <= 1'b1;
      end else begin
         int_ref_en_out <= ref_hold_r
            || (adcs_ref_auto(setup_r.reference_select) && state_r != ST_IDLE);
         ref_pin_drive_en_out <= setup_r.reference_select[2:1] == 2'b11;
         ext_ref_sel_out <= setup_r.reference_select[2:1] == 2'b01;
         vdd_ref_sel_out <= setup_r.reference_select[2:1] == 2'b00;
         shared_pin_input_out <= ~setup_r.reference_select[1];
      end
   end

   // scan plan from the live configuration
   always_comb begin
      cs_lim = (cfg_r.channel_select > LAST_CH) ? LAST_CH : cfg_r.channel_select;
      start_code = cfg_r.channel_select;
      end_code = cfg_r.channel_select;
      case (cfg_r.scan_mode)
         SCAN_UP: begin
            start_code = {3'b000, cfg_r.channel_select[0] & ~cfg_r.single_ended_select};
            end_code = cs_lim;
         end
         SCAN_UPPER: begin
            start_code = UPPER_START | {3'b000, cfg_r.channel_select[0]
               & ~cfg_r.single_ended_select};
            end_code = (cs_lim < start_code) ? start_code : cs_lim;
         end
         default: begin
            start_code = cfg_r.channel_select;
            end_code = cfg_r.channel_select;
         end
      endcase
   end

   // request for the channel now in hand
   always_comb begin
      refpin = setup_r.reference_select[1];
      req.pos = cur_r;
      req.neg = se_r ? cur_r : (cur_r ^ 4'h1);
      req.pos_gnd = refpin && cur_r == LAST_CH;
      req.neg_gnd = se_r || (refpin && req.neg == LAST_CH);
   end

   // sequencing decisions
   assign continuous = ext_r && mode_r[0];
   assign next_code = {1'b0, cur_r} + (step2_r ? 5'h02 : 5'h01);
   always_comb begin
      case (mode_r)
         SCAN_REPEAT: done_last = rep_r == REPEAT_LAST;
         SCAN_SINGLE: done_last = 1'b1;
         default: done_last = next_code > {1'b0, end_r};
      endcase
   end

   // scan state machine
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= ST_IDLE;
         cur_r <= 4'h0;
         end_r <= 4'h0;
         rep_r <= 3'h0;
         mode_r <= SCAN_UP;
         step2_r <= 1'b0;
         se_r <= 1'b0;
         ext_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start_req) begin
                  cur_r <= start_code;
                  end_r <= end_code;
                  rep_r <= 3'h0;
                  mode_r <= cfg_r.scan_mode;
                  step2_r <= ~cfg_r.single_ended_select && !cfg_r.scan_mode[0];
                  se_r <= cfg_r.single_ended_select;
                  ext_r <= setup_r.ext_clock;
                  state_r <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               if (continuous && nack_r) begin
                  state_r <= ST_IDLE;
               end else if (!ext_r || scl_rise) begin
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (conv_done_in) begin
                  if (continuous) begin
                     state_r <= nack_r ? ST_IDLE : ST_ISSUE;
                  end else if (done_last) begin
                     state_r <= ST_IDLE;
                  end else begin
                     state_r <= ST_ISSUE;
                     rep_r <= rep_r + 3'h1;
                     if (!mode_r[0]) begin
                        cur_r <= next_code[3:0];
                     end
                  end
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // not-acknowledge seen during a run
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         nack_r <= 1'b0;
      end else if (master_nack_in) begin
         nack_r <= 1'b1;
      end else if (start_req) begin
         nack_r <= 1'b0;
      end
   end

   // conversion request outputs
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         conv_start_out <= 1'b0;
         conv_req_out <= '0;
      end else begin
         conv_start_out <= 1'b0;
         if (state_r == ST_ISSUE && !(continuous && nack_r) && (!ext_r || scl_rise)) begin
            conv_start_out <= 1'b1;
            conv_req_out <= req;
         end
      end
   end

   // result coding and buffering
   assign result = setup_r.bipolar ? (conv_code_in ^ BIPOLAR_FLIP) : conv_code_in;
   assign push = state_r == ST_WAIT && conv_done_in;

   // overflow flag, a new drop wins over a clear
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ovf_r <= 1'b0;
      end else if (push && full) begin
         ovf_r <= 1'b1;
      end else if (wr_control && wr_data_in[CTL_OVF_CLR_BIT]) begin
         ovf_r <= 1'b0;
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_out <= '0;
      end else if (rd_en_in) begin
         case (addr_in)
            ADDR_CONFIG: rd_data_out <= {1'b0, cfg_r};
            ADDR_SETUP: rd_data_out <= {3'b000, setup_r};
            ADDR_STATUS: begin
               rd_data_out <= '0;
               rd_data_out[STS_BUSY_BIT] <= state_r != ST_IDLE;
               rd_data_out[STS_REF_ON_BIT] <= int_ref_en_out;
               rd_data_out[STS_OVF_BIT] <= ovf_r;
               rd_data_out[STS_COUNT_LSB +: CW] <= count;
            end
            ADDR_RESULT: rd_data_out <= head;
            default: rd_data_out <= '0;
         endcase
      end else begin
         rd_data_out <= '0;
      end
   end

   assign busy_out = state_r != ST_IDLE;
endmodule
`default_nettype wire

/* testbench/adcs_scan_monitor.sv */
// Purpose: port checks for adcs_scan_ctrl
// Assumes: clock source known from setup writes
// Notes: bound to every instance
`timescale 1ns/1ns
`default_nettype none
module adcs_scan_monitor
   import adcs_pkg::*;
#(
   parameter int NUM_INPUTS = 12,
   parameter int BUF_DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // register and bus side
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic master_nack_in,
   // converter and reference
   input wire logic conv_start_out,
   input wire adcs_conv_s conv_req_out,
   input wire logic int_ref_en_out,
   input wire logic ref_pin_drive_en_out,
   input wire logic ext_ref_sel_out,
   input wire logic vdd_ref_sel_out,
   input wire logic shared_pin_input_out,
   input wire logic busy_out
);
   localparam logic [3:0] LAST = 4'(NUM_INPUTS - 1);
   logic ext_r;
   logic setup_wr_r;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   // shadow of the clock source choice
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ext_r <= 1'h0;
      end else if (wr_en_in && addr_in == ADDR_SETUP) begin
         ext_r <= wr_data_in[4];
      end
   end
   // setup write seen one cycle back, the reference follows it a cycle late
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         setup_wr_r <= 1'h0;
      end else begin
         setup_wr_r <= wr_en_in && addr_in == ADDR_SETUP;
      end
   end
   // start write, issue state, start pulse
   sequence s_start_wr;
      wr_en_in && addr_in == ADDR_CONTROL && wr_data_in[CTL_START_BIT] && !busy_out && !ext_r;
   endsequence
   sequence s_issue;
      busy_out ##1 conv_start_out;
   endsequence
   chk_start_issue: assert property (s_start_wr |=> s_issue)
      else $error("start write gave no start pulse");
   chk_vdd_ref: assert property (vdd_ref_sel_out |->
      shared_pin_input_out && !ext_ref_sel_out && !int_ref_en_out)
      else $error("supply reference with wrong state");
   chk_drive_ref: assert property (ref_pin_drive_en_out |->
      int_ref_en_out && !shared_pin_input_out)
      else $error("driven reference with wrong state");
   chk_ext_ref: assert property (ext_ref_sel_out |->
      !int_ref_en_out && !shared_pin_input_out)
      else $error("external reference with wrong state");
   chk_ref_hold: assert property (int_ref_en_out && !busy_out && !$past(busy_out) &&
      !setup_wr_r && !(wr_en_in && addr_in == ADDR_SETUP) |=> int_ref_en_out)
      else $error("internal reference dropped by itself");
   chk_gnd_pos: assert property (conv_start_out |->
      conv_req_out.pos_gnd == (conv_req_out.pos == LAST && !shared_pin_input_out))
      else $error("positive ground flag wrong");
   chk_gnd_neg: assert property (conv_start_out && conv_req_out.pos != conv_req_out.neg |->
      conv_req_out.neg_gnd == (conv_req_out.neg == LAST && !shared_pin_input_out))
      else $error("negative ground flag wrong");
   chk_pair_adj: assert property (conv_start_out |->
      (conv_req_out.pos == conv_req_out.neg ? conv_req_out.neg_gnd :
      (conv_req_out.pos ^ conv_req_out.neg) == 4'h1))
      else $error("inputs neither adjacent pair nor ground referenced");
   chk_chan_range: assert property (conv_start_out |-> conv_req_out.pos < NUM_INPUTS)
      else $error("channel beyond last input");
   chk_nack_end: assert property (ext_r && master_nack_in && busy_out |->
      ##[1:200] !busy_out)
      else $error("run not ended after not-acknowledge");
endmodule
bind adcs_scan_ctrl adcs_scan_monitor #(.NUM_INPUTS(NUM_INPUTS), .BUF_DEPTH(BUF_DEPTH)) mon_i (
   .core_clk_in, .reset_n_in, .addr_in, .wr_data_in, .wr_en_in, .master_nack_in,
   .conv_start_out, .conv_req_out, .int_ref_en_out, .ref_pin_drive_en_out,
   .ext_ref_sel_out, .vdd_ref_sel_out, .shared_pin_input_out, .busy_out
);
`default_nettype wire

/* testbench/adcs_fe_model.sv */
// Purpose: analog front end stand-in on the converter link
// Assumes: one conversion at a time, settable latency
// Notes: code line carries junk outside the done cycle
`timescale 1ns/1ns
`default_nettype none
module adcs_fe_model
   import adcs_pkg::*;
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // latency and link
   input wire logic [3:0] delay_in,
   input wire logic conv_start_in,
   input wire adcs_conv_s conv_req_in,
   output logic conv_done_out,
   output logic [DATA_W-1:0] conv_code_out
);
   logic [3:0] wait_r;
   logic run_r;
   // count latency, then return a code built from the request
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         run_r <= 1'h0;
         wait_r <= 4'h0;
         conv_done_out <= 1'h0;
         conv_code_out <= 8'h5A;
      end else begin
         conv_done_out <= 1'h0;
         conv_code_out <= ~conv_code_out;
         if (conv_start_in) begin
            run_r <= 1'h1;
            wait_r <= delay_in;
         end else if (run_r && wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
         end else if (run_r) begin
            run_r <= 1'h0;
            conv_done_out <= 1'h1;
            conv_code_out[7:4] <= conv_req_in.pos_gnd ? 4'h0 : conv_req_in.pos;
            conv_code_out[3:0] <= conv_req_in.neg_gnd ? 4'h0 : conv_req_in.neg;
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// Purpose: self-checking bench for adcs_scan_ctrl
// Assumes: twelve-input build, front end model on the converter link
// Notes: each scenario task judges its own results
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("unexpected at %0t got %h exp %h", $time, (g), (e)); end end
module tb
   import adcs_pkg::*;
;
   logic core_clk = 1'h0;
   logic reset_n = 1'h0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'h0;
   logic rd_en = 1'h0;
   logic scl = 1'h1;
   logic scl_run = 1'h0;
   logic nack = 1'h0;
   logic [3:0] fe_delay = 4'h2;
   logic [7:0] rd_data, conv_code;
   logic conv_start, conv_done, busy, int_ref, drive_en, ext_ref, vdd_ref, pin_in;
   adcs_conv_s conv_req;
   adcs_conv_s req_q[$];
   adcs_conv_s exp_q[$];
   int miscompares = 0;
   int total_checks = 0;
   localparam logic [3:0] LAST = 4'hB;
   always #5 core_clk = ~core_clk;
   // link clock runs only inside a frame
   always #40 begin
      if (scl_run) scl <= ~scl;
   end
   adcs_scan_ctrl #(.NUM_INPUTS(12), .BUF_DEPTH(16)) adcs_scan_ctrl_i (
      .core_clk_in(core_clk), .reset_n_in(reset_n), .addr_in(addr), .wr_data_in(wr_data),
      .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data), .scl_in(scl),
      .master_nack_in(nack), .conv_start_out(conv_start), .conv_req_out(conv_req),
      .conv_done_in(conv_done), .conv_code_in(conv_code), .int_ref_en_out(int_ref),
      .ref_pin_drive_en_out(drive_en), .ext_ref_sel_out(ext_ref),
      .vdd_ref_sel_out(vdd_ref), .shared_pin_input_out(pin_in), .busy_out(busy)
   );
   adcs_fe_model adcs_fe_model_i (
      .core_clk_in(core_clk), .reset_n_in(reset_n), .delay_in(fe_delay),
      .conv_start_in(conv_start), .conv_req_in(conv_req), .conv_done_out(conv_done),
      .conv_code_out(conv_code)
   );
   // record every request the block issues
   always @(posedge core_clk) begin
      if (conv_start === 1'h1) req_q.push_back(conv_req);
   end
   function automatic adcs_conv_s mk(input logic se, input logic [3:0] p, input logic rp);
      adcs_conv_s c;
      c.pos = p;
      c.neg = se ? p : p ^ 4'h1;
      c.pos_gnd = rp && p == LAST;
      c.neg_gnd = se || (rp && c.neg == LAST);
      return c;
   endfunction
   function automatic logic [7:0] fe_code(input adcs_conv_s c);
      return {c.pos_gnd ? 4'h0 : c.pos, c.neg_gnd ? 4'h0 : c.neg};
   endfunction
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'h1;
      @(posedge core_clk);
      wr_en <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge core_clk);
      rd_en <= 1'h0;
      #1 d = rd_data;
   endtask
   task automatic wait_idle();
      int i;
      repeat (2) tick();
      for (i = 0; i < 3000 && busy !== 1'h0; i++) tick();
      `CHK(busy, 1'h0)
   endtask
   // one started scan against the expected request list
   task automatic run(input logic [7:0] st, input logic [7:0] cfg);
      logic [7:0] d;
      int i;
      req_q.delete();
      wr(ADDR_SETUP, st);
      wr(ADDR_CONFIG, cfg);
      wr(ADDR_CONTROL, 8'h01);
      wait_idle();
      `CHK(req_q.size(), exp_q.size())
      rd(ADDR_STATUS, d);
      `CHK(d[7:3], 5'(exp_q.size()))
      for (i = 0; i < exp_q.size(); i++) begin
         if (i < req_q.size()) `CHK(req_q[i], exp_q[i])
         rd(ADDR_RESULT, d);
         `CHK(d, fe_code(exp_q[i]) ^ (st[3] ? BIPOLAR_FLIP : 8'h00))
      end
      exp_q.delete();
   endtask
   task automatic t_reset();
      logic [7:0] d;
      `CHK({vdd_ref, pin_in, int_ref, drive_en, ext_ref}, 5'h18)
      rd(ADDR_CONFIG, d);
      `CHK(d, 8'h00)
      rd(4'hF, d);
      `CHK(d, 8'h00)
   endtask
   // upward scans, both pair polarities with the reference pin as ground, then single-ended with the supply reference
   task automatic t_scan();
      int i;
      for (i = 0; i < 12; i += 2) exp_q.push_back(mk(1'h0, 4'(i), 1'h1));
      run(8'h02, 8'h0A);
      fe_delay <= 4'h9;
      for (i = 1; i < 12; i += 2) exp_q.push_back(mk(1'h0, 4'(i), 1'h1));
      run(8'h02, 8'h0B);
      for (i = 0; i < 5; i++) exp_q.push_back(mk(1'h1, 4'(i), 1'h0));
      run(8'h08, 8'h44);
      fe_delay <= 4'h0;
   endtask
   task automatic t_modes();
      int i;
      for (i = 0; i < 8; i++) exp_q.push_back(mk(1'h1, 4'h5, 1'h0));
      run(8'h0D, 8'h55);
      exp_q.push_back(mk(1'h1, 4'h6, 1'h0));
      run(8'h00, 8'h63);
      for (i = 6; i < 10; i++) exp_q.push_back(mk(1'h1, 4'(i), 1'h0));
      run(8'h00, 8'h69);
      for (i = 6; i < 12; i += 2) exp_q.push_back(mk(1'h0, 4'(i), 1'h0));
      run(8'h00, 8'h2A);
      exp_q.push_back(mk(1'h1, LAST, 1'h1));
      run(8'h06, 8'h7B);
   endtask
   // every reference setting, then hold and release of the reference
   task automatic t_ref();
      int s;
      logic [7:0] d;
      for (s = 0; s < 8; s++) begin
         wr(ADDR_SETUP, 8'(s));
         repeat (2) tick();
         `CHK({vdd_ref, ext_ref}, {1'(s < 2), 1'(s == 2 || s == 3)})
         `CHK(pin_in, 1'(s < 2 || s == 4 || s == 5))
         `CHK({drive_en, int_ref}, {1'(s > 5), 1'(s > 4)})
      end
      wr(ADDR_CONFIG, 8'h40);
      rd(ADDR_STATUS, d);
      `CHK(d[STS_REF_ON_BIT], 1'h1)
      wr(ADDR_SETUP, 8'h04);
      repeat (2) tick();
      `CHK(int_ref, 1'h0)
   endtask
   // link-clocked repeat and single modes stop on not-acknowledge
   task automatic t_ext();
      int m, i;
      logic [7:0] d;
      for (m = 1; m < 4; m += 2) begin
         req_q.delete();
         wr(ADDR_SETUP, 8'h10);
         wr(ADDR_CONFIG, 8'h42 | 8'(m << 4));
         wr(ADDR_CONTROL, 8'h01);
         scl_run <= 1'h1;
         for (i = 0; i < 3000 && req_q.size() < 3; i++) tick();
         @(posedge core_clk);
         nack <= 1'h1;
         @(posedge core_clk);
         nack <= 1'h0;
         wait_idle();
         scl_run <= 1'h0;
         `CHK(req_q.size() inside {[3:4]}, 1'h1)
         for (i = 0; i < req_q.size(); i++) `CHK(req_q[i], mk(1'h1, 4'h2, 1'h0))
         rd(ADDR_STATUS, d);
         `CHK(d[7:3], 5'(req_q.size()))
         wr(ADDR_CONTROL, 8'h02);
         rd(ADDR_STATUS, d);
         `CHK(d[7:3], 5'h00)
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      reset_n <= 1'h1;
      tick();
      t_reset();
      t_scan();
      t_modes();
      t_ref();
      t_ext();
      stop_test();
   end
   // watchdog well beyond the expected run
   initial begin
      #400000;
      miscompares++;
      stop_test();
   end
endmodule
`default_nettype wire
